/* rs_pkg.sv */
package rs_pkg;

	// Instruction word layout
	localparam int INSN_W = 12;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam int DEST_BIT = 5;
	localparam int ADDR_HI = 4;
	localparam int ADDR_LO = 0;
	localparam int OPC_HI = 11;
	localparam int OPC_LO = 6;
	localparam int MSB = 7;
	localparam int CARRY_BIT = 0;

	// Opcode patterns
	localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
	localparam logic [5:0] OPC_ROT_RIGHT = 6'h0c;
	localparam logic [11:0] OPC_HALT = 12'h003;

	// Oscillator periods per instruction cycle
	localparam int OSC_PER_CYCLE = 4;

	// Register map on the AHB-Lite bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSN = 8'h04;
	localparam logic [7:0] OFF_ACC = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_WDOG = 8'h10;
	localparam logic [7:0] OFF_PRESC = 8'h14;
	localparam logic [7:0] OFF_FILE = 8'h80;
	localparam int FILE_DEPTH = 32;

	// Status register bits
	localparam int STAT_EXPIRY = 4;
	localparam int STAT_SLEEP = 3;
	localparam logic [7:0] STATUS_RST = 8'h18;

	// Control register bits
	localparam int CTRL_PSA = 0;
	localparam int CTRL_WAKE = 1;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
	} ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_s;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_EXEC,
		ST_HALT
	} core_e;

endpackage

/* rotate_and_sleep_execution.sv */
// Function
// - Left rotate opcode shifts the file register left with carry into bit 0 and bit 7 out to carry, in one cycle.
// - Right rotate opcode shifts the file register right with carry into bit 7 and bit 0 out to carry, in one cycle.
// - Both rotates use status bit 0 as carry and change no other flag.
// - A clear destination bit sends the result to the accumulator, a set one back to the file register.
// - Halt clears the watchdog counter, sets the expiry flag and clears the sleep entry flag.
// - Halt clears the prescaler only when it is assigned to the watchdog.
// - The halt opcode takes one cycle, enters the halt state and stops the oscillator.
// - One instruction cycle is four oscillator periods.
// - Bit 5 selects the destination and bits 4 to 0 address the file register.
module rotate_and_sleep_execution #(
	parameter int WDOG_W = 8,
	parameter int PRESC_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire rs_pkg::ahb_req_s ahb_req,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output rs_pkg::ahb_rsp_s ahb_rsp,
	output logic osc_run,
	output logic halted
);

	localparam int PH_W = $clog2(rs_pkg::OSC_PER_CYCLE);
	localparam logic [PH_W-1:0] PH_LAST =
		PH_W'(rs_pkg::OSC_PER_CYCLE - 1);

	logic [rs_pkg::DATA_W-1:0] file_r [rs_pkg::FILE_DEPTH];
	logic [rs_pkg::DATA_W-1:0] acc_r;
	logic [rs_pkg::DATA_W-1:0] status_r;
	logic [WDOG_W-1:0] watchdog_counter_r;
	logic [PRESC_W-1:0] presc_r;
	logic [1:0] ctrl_r;
	logic [rs_pkg::INSN_W-1:0] insn_r;
	logic [PH_W-1:0] phase_r;
	rs_pkg::core_e state_r;

	// Captured address phase
	logic dp_valid_r;
	logic dp_write_r;
	logic [7:0] dp_addr_r;
	logic [31:0] rdata_r;

	// Decode of the pending instruction
	logic [5:0] opc;
	logic dest_f;
	logic [rs_pkg::ADDR_W-1:0] faddr;
	logic [rs_pkg::DATA_W-1:0] src;
	logic carry_in;
	logic [rs_pkg::DATA_W-1:0] rot_res;
	logic rot_carry;
	logic is_left;
	logic is_right;
	logic is_halt;
	logic cycle_end;
	logic exec;

	assign opc = insn_r[rs_pkg::OPC_HI:rs_pkg::OPC_LO];
	assign dest_f = insn_r[rs_pkg::DEST_BIT];
	assign faddr = insn_r[rs_pkg::ADDR_HI:rs_pkg::ADDR_LO];
	assign src = file_r[faddr];
	assign carry_in = status_r[rs_pkg::CARRY_BIT];
	assign is_left = (opc == rs_pkg::OPC_ROT_LEFT);
	assign is_right = (opc == rs_pkg::OPC_ROT_RIGHT);
	assign is_halt = (insn_r == rs_pkg::OPC_HALT);
	assign cycle_end = (phase_r == PH_LAST);
	assign exec = (state_r == rs_pkg::ST_EXEC) && cycle_end;

	// Rotate datapath through carry
	always_comb begin
		if (is_left) begin
			rot_res = {src[rs_pkg::MSB-1:0], carry_in};
			rot_carry = src[rs_pkg::MSB];
		end else begin
			rot_res = {carry_in, src[rs_pkg::MSB:1]};
			rot_carry = src[0];
		end
	end

	// Oscillator phase count; cleared to zero while halted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r <= '0;
		end else if (state_r != rs_pkg::ST_HALT) begin
			phase_r <= phase_r + PH_W'(1);
		end else begin
			phase_r <= '0;
		end
	end

	// Bus write strobe in the data phase
	logic wr_en;
	assign wr_en = dp_valid_r && dp_write_r;

	// Core state: issue on bus write, execute at cycle end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= rs_pkg::ST_RUN;
		end else begin
			unique case (state_r)
				rs_pkg::ST_RUN: begin
					if (wr_en && dp_addr_r == rs_pkg::OFF_INSN) begin
						state_r <= rs_pkg::ST_EXEC;
					end
				end
				rs_pkg::ST_EXEC: begin
					if (cycle_end) begin
						// Halt stops the oscillator in one cycle
						state_r <= is_halt ? rs_pkg::ST_HALT
							: rs_pkg::ST_RUN;
					end
				end
				rs_pkg::ST_HALT: begin
					// Wake-up is outside this block; software kick only
					if (wr_en && dp_addr_r == rs_pkg::OFF_CTRL &&
						hwdata[rs_pkg::CTRL_WAKE]) begin
						state_r <= rs_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	// Instruction word latch; ignored while one is pending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			insn_r <= '0;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_INSN &&
			state_r == rs_pkg::ST_RUN) begin
			insn_r <= hwdata[rs_pkg::INSN_W-1:0];
		end
	end

	// File registers; rotate write-back only when destination is f
	for (genvar i = 0; i < rs_pkg::FILE_DEPTH; i++) begin : g_file
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				file_r[i] <= '0;
			end else if (exec && (is_left || is_right) && dest_f &&
				faddr == rs_pkg::ADDR_W'(i)) begin
				file_r[i] <= rot_res;
			end else if (wr_en && dp_addr_r ==
				rs_pkg::OFF_FILE + 8'(i * 4)) begin
				file_r[i] <= hwdata[rs_pkg::DATA_W-1:0];
			end
		end
	end

	// Accumulator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r <= '0;
		end else if (exec && (is_left || is_right) && !dest_f) begin
			acc_r <= rot_res;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_ACC) begin
			acc_r <= hwdata[rs_pkg::DATA_W-1:0];
		end
	end

	// Status: carry by rotates, flags by halt; execution beats bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= rs_pkg::STATUS_RST;
		end else if (exec && (is_left || is_right)) begin
			status_r[rs_pkg::CARRY_BIT] <= rot_carry;
		end else if (exec && is_halt) begin
			status_r[rs_pkg::STAT_EXPIRY] <= 1'b1;
			status_r[rs_pkg::STAT_SLEEP] <= 1'b0;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_STATUS) begin
			status_r <= hwdata[rs_pkg::DATA_W-1:0];
		end
	end

	// Watchdog counter image; the timer itself lives elsewhere
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_counter_r <= '0;
		end else if (exec && is_halt) begin
			watchdog_counter_r <= '0;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_WDOG) begin
			watchdog_counter_r <= hwdata[WDOG_W-1:0];
		end
	end

	// Shared prescaler cleared only when owned by the watchdog
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_r <= '0;
		end else if (exec && is_halt && ctrl_r[rs_pkg::CTRL_PSA]) begin
			presc_r <= '0;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_PRESC) begin
			presc_r <= hwdata[PRESC_W-1:0];
		end
	end

	// Control: prescaler assignment; wake bit is self-clearing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= '0;
		end else if (wr_en && dp_addr_r == rs_pkg::OFF_CTRL) begin
			ctrl_r <= {1'b0, hwdata[rs_pkg::CTRL_PSA]};
		end
	end

	// AHB-Lite address phase capture; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= '0;
		end else if (hready) begin
			dp_valid_r <= ahb_req.hsel && ahb_req.htrans[1];
			dp_write_r <= ahb_req.hwrite;
			dp_addr_r <= ahb_req.haddr[7:0];
		end
	end

	// Read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= '0;
		end else if (hready && ahb_req.hsel && ahb_req.htrans[1] &&
			!ahb_req.hwrite) begin
			if (ahb_req.haddr[7] && ahb_req.haddr[1:0] == 2'h0) begin
				rdata_r <= {24'h000000, file_r[ahb_req.haddr[6:2]]};
			end else begin
				unique case (ahb_req.haddr[7:0])
					rs_pkg::OFF_CTRL: rdata_r <= {30'h0, ctrl_r};
					rs_pkg::OFF_INSN: rdata_r <= {20'h0, insn_r};
					rs_pkg::OFF_ACC: rdata_r <= {24'h0, acc_r};
					rs_pkg::OFF_STATUS: rdata_r <= {24'h0, status_r};
					rs_pkg::OFF_WDOG:
						rdata_r <= 32'(watchdog_counter_r);
					rs_pkg::OFF_PRESC: rdata_r <= 32'(presc_r);
					default: rdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign ahb_rsp.hrdata = rdata_r;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign halted = (state_r == rs_pkg::ST_HALT);
	assign osc_run = (state_r != rs_pkg::ST_HALT);

endmodule

/* rse_chk.sv */
module rse_chk #(
	parameter int WDOG_W = 8,
	parameter int PRESC_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire rs_pkg::ahb_req_s ahb_req,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire rs_pkg::ahb_rsp_s ahb_rsp,
	input wire logic osc_run,
	input wire logic halted
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Address phase decode, same take condition as the slave
	logic ap;
	logic [7:0] a;
	assign ap = ahb_req.hsel && ahb_req.htrans[1] && hready;
	assign a = ahb_req.haddr[7:0];

	// Read address phase at one offset
	sequence s_rd(logic [7:0] x);
		ap && !ahb_req.hwrite && a == x;
	endsequence
	// Halt opcode written while running, then its data phase
	sequence s_wr_halt;
		ap && ahb_req.hwrite && a == rs_pkg::OFF_INSN && !halted
		##1 hwdata[11:0] == rs_pkg::OPC_HALT;
	endsequence

	property p_rdy;
		ahb_rsp.hreadyout == 1'b1;
	endproperty
	a_rdy: assert property (p_rdy) else $error("slave inserted a wait");
	property p_okay;
		ahb_rsp.hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("slave gave an error");
	property p_osc;
		osc_run == !halted;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator runs in halt");
	// Phase counter runs free: halt shows two to five clocks after data edge
	property p_halt_go;
		s_wr_halt |-> ##1 !halted ##[1:4] halted;
	endproperty
	a_halt_go: assert property (p_halt_go)
		else $error("halt not entered");
	property p_unmap;
		s_rd(8'h40) |=> ahb_rsp.hrdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_upper;
		ap && !ahb_req.hwrite |=> ahb_rsp.hrdata[31:12] == 20'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_wdog;
		s_rd(rs_pkg::OFF_WDOG) ##0 halted |=> ahb_rsp.hrdata == 32'h0;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog not clear");
	property p_stat;
		s_rd(rs_pkg::OFF_STATUS) ##0 halted |=> ahb_rsp.hrdata[4:3] == 2'b10;
	endproperty
	a_stat: assert property (p_stat) else $error("halt flags wrong");
endmodule

bind rotate_and_sleep_execution rse_chk #(.WDOG_W(WDOG_W), .PRESC_W(PRESC_W))
	u_chk (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hready(hready),
	.hwdata(hwdata), .ahb_rsp(ahb_rsp), .osc_run(osc_run), .halted(halted));

/* tb_rotate_and_sleep_execution.sv */
module tb_rotate_and_sleep_execution;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	rs_pkg::ahb_req_s req = '0;
	logic [31:0] hwdata = 32'h0;
	rs_pkg::ahb_rsp_s rsp;
	logic osc_run;
	logic halted;
	logic [31:0] q;
	int fails = 0;
	int comparisons = 0;

	// 100 MHz bus clock
	always #5 hclk = ~hclk;

	rotate_and_sleep_execution DUT (.hclk(hclk), .hresetn(hresetn),
		.ahb_req(req), .hready(rsp.hreadyout), .hwdata(hwdata),
		.ahb_rsp(rsp), .osc_run(osc_run), .halted(halted));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Bounded wait for hready, so a stuck slave still ends the run
	task automatic wrdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (rsp.hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				test_done();
			end
			@(posedge hclk);
		end
	endtask

	// One single word transfer; read data taken at the data phase edge
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge hclk);
		req <= '{haddr: {24'h0, a}, htrans: 2'b10, hwrite: w,
			hsize: 3'b010, hsel: 1'b1};
		wrdy();
		req.htrans <= 2'b00;
		req.hsel <= 1'b0;
		hwdata <= d;
		wrdy();
		q = rsp.hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK(q, e)
	endtask

	// Phase counter may need a full instruction cycle plus one clock
	task automatic exec(input logic [11:0] insn);
		xfer(rs_pkg::OFF_INSN, 1'b1, {20'h0, insn});
		repeat (5) @(posedge hclk);
	endtask

	initial begin
		repeat (12) @(posedge hclk);
		`CHK({halted, osc_run}, 2'b01)
		hresetn <= 1'b1;
		rd(rs_pkg::OFF_STATUS, {24'h0, rs_pkg::STATUS_RST});
		xfer(8'h40, 1'b1, 32'hffff_ffff);
		rd(8'h40, 32'h0);
		$display("test reset done");
		// File 5 left into the accumulator, carry clear
		xfer(8'h94, 1'b1, 32'he6);
		exec(12'h345);
		rd(rs_pkg::OFF_ACC, 32'hcc);
		rd(8'h94, 32'he6);
		rd(rs_pkg::OFF_STATUS, 32'h19);
		$display("test left done");
		// Top file 31 right back into itself, carry set
		xfer(8'hfc, 1'b1, 32'he6);
		exec(12'h33f);
		rd(8'hfc, 32'hf3);
		rd(rs_pkg::OFF_ACC, 32'hcc);
		rd(rs_pkg::OFF_STATUS, 32'h18);
		$display("test right done");
		// Halt with the prescaler elsewhere, then assigned
		for (int p = 0; p < 2; p++) begin
			xfer(rs_pkg::OFF_CTRL, 1'b1, 32'(p));
			xfer(rs_pkg::OFF_WDOG, 1'b1, 32'h55);
			xfer(rs_pkg::OFF_PRESC, 1'b1, 32'h33);
			// Expiry clear beforehand, so the set is seen; low bits kept
			xfer(rs_pkg::OFF_STATUS, 1'b1, 32'h0f);
			exec(rs_pkg::OPC_HALT);
			`CHK({halted, osc_run}, 2'b10)
			rd(rs_pkg::OFF_WDOG, 32'h0);
			rd(rs_pkg::OFF_PRESC, (p == 1) ? 32'h0 : 32'h33);
			rd(rs_pkg::OFF_STATUS, 32'h17);
			xfer(rs_pkg::OFF_CTRL, 1'b1, 32'h2);
			repeat (5) @(posedge hclk);
			`CHK({halted, osc_run}, 2'b01)
			$display("test halt done");
		end
		test_done();
	end
endmodule
